// ---- rtl/mbd_map.svh ----
// Constants for the diagnostic and status command responder
`ifndef MBD_MAP_SVH
`define MBD_MAP_SVH
// Function codes
`define MBD_FC_READ_HOLD   8'h03
`define MBD_FC_DIAG        8'h08
`define MBD_FC_EVT_CNT     8'h0b
`define MBD_FC_EVT_LOG     8'h0c
`define MBD_FC_SLAVE_ID    8'h11
`define MBD_FC_DEV_ID      8'h2b
// Diagnostic subfunctions
`define MBD_SF_ECHO        16'h0000
`define MBD_SF_RESTART     16'h0001
`define MBD_SF_DIAG_REG    16'h0002
`define MBD_SF_LISTEN      16'h0004
`define MBD_SF_CLEAR       16'h000a
`define MBD_SF_CNT_FIRST   16'h000b
`define MBD_SF_CNT_LAST    16'h0012
// Exception codes
`define MBD_EXC_FUNC       8'h01
`define MBD_EXC_ADDR       8'h02
`define MBD_EXC_VALUE      8'h03
`define MBD_EXC_BUSY       8'h06
// Status word values
`define MBD_STAT_BUSY      16'hffff
`define MBD_STAT_IDLE      16'h0000
// Run indicator
`define MBD_RUN_ON         8'hff
`define MBD_RUN_OFF        8'h00
// Gateway own kind and status
`define MBD_GW_KIND        16'h00ff
`define MBD_GW_STATUS      16'h0001
// Kind code limits
`define MBD_KIND_RSVD      5'h06
`define MBD_KIND_DP_FIRST  5'h0b
`define MBD_KIND_LAST      5'h14
// Field unit limits
`define MBD_UNIT_FIRST     6'h01
`define MBD_UNIT_LAST      6'h32
// Holding register layout per unit
`define MBD_REGS_PER_UNIT  16'h000a
`define MBD_REG_KIND       16'h0000
`define MBD_REG_COND       16'h0002
// Condition flag positions
`define MBD_CF_ONLINE      0
`define MBD_CF_SQRT        8
// Event log bytes
`define MBD_LOG_RX         8'h80
`define MBD_LOG_RX_LISTEN  8'h20
`define MBD_LOG_RESTART    8'h00
`define MBD_LOG_LISTEN     8'h04
// Diagnostics register listen-only bit
`define MBD_DIAG_LISTEN    0
// Identification
`define MBD_CONFORMITY     16'h0001
`define MBD_ID_VENDOR      8'h00
`define MBD_ID_PRODUCT     8'h01
`define MBD_ID_REVISION    8'h02
// Identification object values, arbitrary
`define MBD_OBJ_VEND       32'h00000a01
`define MBD_OBJ_PROD       32'h00000b02
`define MBD_OBJ_REV        32'h00000c03
// Float exponent bias
`define MBD_FLT_BIAS       8'h7f
`endif

// ---- rtl/mbd_pkg.sv ----
// Types for the diagnostic and status command responder
package mbd_pkg;
	typedef struct packed {
		logic        valid;
		logic [7:0]  addr;
		logic [7:0]  func;
		logic [15:0] sub;
		logic [15:0] data;
	} mbd_req_t;

	typedef struct packed {
		logic        valid;
		logic        exc;
		logic [7:0]  code;
		logic [7:0]  func;
		logic [15:0] w0;
		logic [15:0] w1;
		logic [31:0] w2;
		logic [7:0]  run;
		logic [55:0] log;
	} mbd_rsp_t;

	typedef struct packed {
		logic        sqrt_on;
		logic        sw2_high;
		logic        sw1_high;
		logic        sys_err;
		logic        overrange;
		logic        sens_err;
		logic        alarm;
		logic        low_batt;
		logic        online;
	} mbd_cond_t;

	typedef struct packed {
		logic [4:0] kind;
		mbd_cond_t  cond;
	} mbd_unit_t;

	typedef struct packed {
		logic bus_msg;
		logic comm_err;
		logic overrun;
		logic nak;
	} mbd_ev_t;
endpackage : mbd_pkg

// ---- rtl/mbd_slave.sv ----
// Modbus slave diagnostic and field unit status responder
// Operation
// - Field unit kind code is presented as a 32-bit float by function 3; function 17 gives it as a word.
// - Kind codes 0 to 10 are basic kinds; 6 is never reported.
// - Kind codes 11 to 20 are differential pressure variants.
// - Condition flags are bit weights carried as a 32-bit float by function 3; function 17 gives them as a word.
// - Several active conditions report the sum of their weights.
// - Diagnostic 0 echoes, 1 restarts, 2 returns register, 4 listens.
// - Subfunction 3, 5 to 9 and 19 upward are unsupported.
// - Subfunction 10 clears the eight diagnostic counters and the diagnostics register, not the event counter.
// - Subfunctions 11 to 18 each return one counter in order.
// - Diagnostic results are identical for every served address.
// - Function 11 returns status word and event counter.
// - Event counter counts good messages, not exceptions or fetches.
// - Event counter wraps to zero after 65535.
// - Function 12 returns status, event count, message count, log.
// - Message count includes messages for any station.
// - Event log keeps the seven most recent events.
// - Function 17 returns kind word, status word and run byte.
// - Run byte is ff when unit online, 00 when offline.
// - Function 17 answer depends on the addressed unit.
// - Function 43 returns basic identification at level 01.
// - Mapped unit answers at base address plus radio identifier.
`timescale 1ns/1ns
`default_nettype none
`include "mbd_map.svh"

module mbd_slave (
	// Clock, reset, enable
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	// Configuration
	input  wire logic [7:0]       base_addr,
	input  wire logic             per_unit_address_mapping,
	input  wire logic             cmd_busy,
	// Field unit updates from the radio side
	input  wire logic             unit_wr,
	input  wire logic [5:0]       radio_unit_identifier,
	input  wire mbd_pkg::mbd_unit_t unit_data,
	// Decoded requests and bus events
	input  wire mbd_pkg::mbd_req_t  req,
	input  wire mbd_pkg::mbd_ev_t   bus_ev,
	// Response and mode
	output var  mbd_pkg::mbd_rsp_t  rsp,
	output var  logic             listen_only
);

	// Integer to single precision float
	function automatic logic [31:0] to_float(input logic [8:0] v);
		logic [7:0]  e;
		logic [22:0] m;
		int          p;
		p = 0;
		for (int i = 0; i < 9; i++) begin
			if (v[i]) begin
				p = i;
			end
		end
		e = `MBD_FLT_BIAS + 8'(p);
		m = 23'({14'h0000, v} << (23 - p));
		to_float = (v == 9'h000) ? 32'h00000000 : {1'b0, e, m};
	endfunction : to_float

	// Condition weights: field order gives 1,2,4,...,256
	function automatic logic [8:0] cond_word(input mbd_pkg::mbd_unit_t u);
		logic [8:0] w;
		w = u.cond;
		w[`MBD_CF_SQRT] = u.cond.sqrt_on
			&& (u.kind >= `MBD_KIND_DP_FIRST);
		cond_word = w;
	endfunction : cond_word

	// Field unit table
	mbd_pkg::mbd_unit_t unit_mem [0:63];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 64; i++) begin
				unit_mem[i] <= '0;
			end
		end else if (clk_en && unit_wr
			&& radio_unit_identifier >= `MBD_UNIT_FIRST
			&& radio_unit_identifier <= `MBD_UNIT_LAST
			&& unit_data.kind != `MBD_KIND_RSVD
			&& unit_data.kind <= `MBD_KIND_LAST) begin
			unit_mem[radio_unit_identifier] <= unit_data;
		end
	end

	// State
	logic [15:0]       cnt_reg [0:7];
	logic [15:0]       cnt_next [0:7];
	logic [15:0]       evt_reg;
	logic [15:0]       evt_next;
	logic [15:0]       diag_reg;
	logic [15:0]       diag_next;
	logic              listen_reg;
	logic              listen_next;
	logic [55:0]       log_reg;
	logic [55:0]       log_next;
	mbd_pkg::mbd_rsp_t rsp_reg;
	mbd_pkg::mbd_rsp_t rsp_next;

	// Address decode
	logic [7:0]        ofs;
	logic              hit_gw;
	logic              hit_unit;
	logic [5:0]        dev_id;
	logic [15:0]       reg_ofs;
	logic [5:0]        reg_id;
	mbd_pkg::mbd_unit_t dev_u;
	mbd_pkg::mbd_unit_t reg_u;
	logic [15:0]       stat_word;

	always_comb begin
		ofs = req.addr - base_addr;
		hit_gw = (req.addr == base_addr);
		hit_unit = per_unit_address_mapping
			&& ofs >= 8'(`MBD_UNIT_FIRST)
			&& ofs <= 8'(`MBD_UNIT_LAST);
		dev_id = hit_unit ? ofs[5:0] : 6'h00;
		dev_u = unit_mem[dev_id];
		reg_id = 6'(req.sub / `MBD_REGS_PER_UNIT);
		reg_ofs = req.sub - 16'(reg_id) * `MBD_REGS_PER_UNIT;
		reg_u = unit_mem[reg_id];
		stat_word = cmd_busy ? `MBD_STAT_BUSY : `MBD_STAT_IDLE;
	end

	always_comb begin
		mbd_pkg::mbd_unit_t u;
		logic [15:0] rofs;
		logic        good;
		logic        fetch;
		logic        clr;
		logic        clr_evt;
		u = '0;
		rofs = '0;
		good = 1'b0;
		fetch = 1'b0;
		clr = 1'b0;
		clr_evt = 1'b0;
		for (int i = 0; i < 8; i++) begin
			cnt_next[i] = cnt_reg[i];
		end
		evt_next = evt_reg;
		diag_next = diag_reg;
		listen_next = listen_reg;
		log_next = log_reg;
		rsp_next = rsp_reg;
		rsp_next.valid = 1'b0;
		// Bus wide counts
		if (bus_ev.bus_msg) begin
			cnt_next[0] = cnt_reg[0] + 16'h0001;
		end
		if (bus_ev.comm_err) begin
			cnt_next[1] = cnt_reg[1] + 16'h0001;
		end
		if (bus_ev.nak) begin
			cnt_next[5] = cnt_reg[5] + 16'h0001;
		end
		if (bus_ev.overrun) begin
			cnt_next[7] = cnt_reg[7] + 16'h0001;
		end
		if (req.valid && (hit_gw || hit_unit)) begin
			cnt_next[3] = cnt_reg[3] + 16'h0001;
			log_next = {log_reg[47:0], `MBD_LOG_RX
				| (listen_reg ? `MBD_LOG_RX_LISTEN : 8'h00)};
			rsp_next = '0;
			rsp_next.func = req.func;
			rsp_next.log = log_reg;
			if (listen_reg) begin
				cnt_next[4] = cnt_reg[4] + 16'h0001;
				if (req.func == `MBD_FC_DIAG
					&& req.sub == `MBD_SF_RESTART) begin
					listen_next = 1'b0;
					diag_next[`MBD_DIAG_LISTEN] = 1'b0;
					log_next = {log_reg[47:0], `MBD_LOG_RESTART};
				end
			end else if (cmd_busy && req.func != `MBD_FC_EVT_CNT
				&& req.func != `MBD_FC_EVT_LOG) begin
				cnt_next[6] = cnt_reg[6] + 16'h0001;
				cnt_next[2] = cnt_reg[2] + 16'h0001;
				rsp_next.valid = 1'b1;
				rsp_next.exc = 1'b1;
				rsp_next.code = `MBD_EXC_BUSY;
			end else begin
				rsp_next.valid = 1'b1;
				good = 1'b1;
				unique case (req.func)
					`MBD_FC_READ_HOLD: begin
						u = hit_unit ? dev_u : reg_u;
						rofs = hit_unit ? req.sub : reg_ofs;
						if (hit_gw && !per_unit_address_mapping
							&& reg_id == 6'h00) begin
							rsp_next.w0 = `MBD_GW_KIND;
							rsp_next.w1 = `MBD_GW_STATUS;
						end else if (rofs == `MBD_REG_KIND) begin
							rsp_next.w2 = to_float({4'h0, u.kind});
						end else if (rofs == `MBD_REG_COND) begin
							rsp_next.w2 = to_float(cond_word(u));
						end else begin
							good = 1'b0;
							rsp_next.exc = 1'b1;
							rsp_next.code = `MBD_EXC_ADDR;
						end
					end
					`MBD_FC_DIAG: begin
						rsp_next.w0 = req.sub;
						unique case (req.sub)
							`MBD_SF_ECHO: begin
								rsp_next.w1 = req.data;
							end
							`MBD_SF_RESTART: begin
								rsp_next.w1 = req.data;
								clr = 1'b1;
								clr_evt = 1'b1;
								log_next = {log_reg[47:0], `MBD_LOG_RESTART};
							end
							`MBD_SF_DIAG_REG: begin
								rsp_next.w1 = diag_reg;
							end
							`MBD_SF_LISTEN: begin
								rsp_next.valid = 1'b0;
								listen_next = 1'b1;
								diag_next[`MBD_DIAG_LISTEN] = 1'b1;
								log_next = {log_reg[47:0], `MBD_LOG_LISTEN};
							end
							`MBD_SF_CLEAR: begin
								clr = 1'b1;
								diag_next = 16'h0000;
								rsp_next.w1 = req.data;
							end
							default: begin
								if (req.sub >= `MBD_SF_CNT_FIRST
									&& req.sub <= `MBD_SF_CNT_LAST) begin
									rsp_next.w1 = cnt_reg[3'(req.sub
										- `MBD_SF_CNT_FIRST)];
								end else begin
									good = 1'b0;
									rsp_next.exc = 1'b1;
									rsp_next.code = `MBD_EXC_VALUE;
								end
							end
						endcase
					end
					`MBD_FC_EVT_CNT: begin
						fetch = 1'b1;
						rsp_next.w0 = stat_word;
						rsp_next.w1 = evt_reg;
					end
					`MBD_FC_EVT_LOG: begin
						fetch = 1'b1;
						rsp_next.w0 = stat_word;
						rsp_next.w1 = evt_reg;
						rsp_next.w2 = {16'h0000, cnt_reg[0]};
					end
					`MBD_FC_SLAVE_ID: begin
						if (hit_unit) begin
							rsp_next.w0 = {11'h000, dev_u.kind};
							rsp_next.w1 = {7'h00, cond_word(dev_u)};
							rsp_next.run = dev_u.cond.online
								? `MBD_RUN_ON : `MBD_RUN_OFF;
						end else begin
							rsp_next.w0 = `MBD_GW_KIND;
							rsp_next.w1 = `MBD_GW_STATUS;
							rsp_next.run = `MBD_RUN_ON;
						end
					end
					`MBD_FC_DEV_ID: begin
						rsp_next.w0 = `MBD_CONFORMITY;
						rsp_next.w1 = req.sub;
						unique case (req.sub[7:0])
							`MBD_ID_VENDOR:   rsp_next.w2 = `MBD_OBJ_VEND;
							`MBD_ID_PRODUCT:  rsp_next.w2 = `MBD_OBJ_PROD;
							`MBD_ID_REVISION: rsp_next.w2 = `MBD_OBJ_REV;
							default: begin
								good = 1'b0;
								rsp_next.exc = 1'b1;
								rsp_next.code = `MBD_EXC_ADDR;
							end
						endcase
					end
					default: begin
						good = 1'b0;
						rsp_next.exc = 1'b1;
						rsp_next.code = `MBD_EXC_FUNC;
					end
				endcase
				if (rsp_next.exc) begin
					cnt_next[2] = cnt_reg[2] + 16'h0001;
				end
				if (good && !fetch) begin
					evt_next = evt_reg + 16'h0001;
				end
			end
		end
		for (int i = 0; i < 8; i++) begin
			cnt_next[i] = clr ? cnt_next[i] - cnt_reg[i] : cnt_next[i];
		end
		evt_next = clr_evt ? evt_next - evt_reg : evt_next;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				cnt_reg[i] <= 16'h0000;
			end
			evt_reg <= 16'h0000;
			diag_reg <= 16'h0000;
			listen_reg <= 1'b0;
			log_reg <= '0;
			rsp_reg <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < 8; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
			evt_reg <= evt_next;
			diag_reg <= diag_next;
			listen_reg <= listen_next;
			log_reg <= log_next;
			rsp_reg <= rsp_next;
		end
	end

	assign rsp = rsp_reg;
	assign listen_only = listen_reg;

endmodule : mbd_slave
`default_nettype wire

// ---- tb/mbd_slave_monitor.sv ----
// Concurrent checks on the responder ports
`timescale 1ns/1ns
`default_nettype none
module mbd_slave_monitor (
	// Clock, reset, enable
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              clk_en,
	// Configuration
	input wire logic [7:0]        base_addr,
	input wire logic              per_unit_address_mapping,
	input wire logic              cmd_busy,
	// Field unit updates
	input wire logic              unit_wr,
	input wire logic [5:0]        radio_unit_identifier,
	input wire mbd_pkg::mbd_unit_t unit_data,
	// Requests, events, answers
	input wire mbd_pkg::mbd_req_t  req,
	input wire mbd_pkg::mbd_ev_t   bus_ev,
	input wire mbd_pkg::mbd_rsp_t  rsp,
	input wire logic              listen_only
);
	logic [7:0] ofs;
	logic       hit;
	logic       hl;
	logic       hb;
	assign ofs = req.addr - base_addr;
	assign hit = req.valid && clk_en && (req.addr == base_addr ||
		per_unit_address_mapping && ofs >= 8'h01 && ofs <= 8'h32);
	assign hl = hit && !listen_only;
	assign hb = hl && !cmd_busy;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_answer_next: assert property (
		hl && !(req.func == 8'h08 && req.sub == 16'h4) |=> rsp.valid)
		else $error("answer missing");
	a_unaddr_quiet: assert property (
		req.valid && !hit |=> !rsp.valid) else $error("answer to other");
	a_listen_silent: assert property (
		listen_only |=> !rsp.valid) else $error("answer in listen");
	a_listen_stays: assert property (
		listen_only && !(hit && req.func == 8'h08 && req.sub == 16'h1)
		|=> listen_only) else $error("listen left early");
	a_listen_enter: assert property (
		hb && req.func == 8'h08 && req.sub == 16'h4 |=> listen_only
		&& !rsp.valid) else $error("listen not entered");
	a_status_word: assert property (
		hl && (req.func == 8'h0b || req.func == 8'h0c) |=> rsp.w0 ==
		($past(cmd_busy) ? 16'hffff : 16'h0000)) else $error("bad status");
	a_bad_sub: assert property (
		hb && req.func == 8'h08 && (req.sub == 16'h3 || req.sub >= 16'h5
		&& req.sub <= 16'h9 || req.sub >= 16'h13) |=> rsp.exc &&
		rsp.code == 8'h03) else $error("bad subfunction accepted");
	a_echo_data: assert property (
		hb && req.func == 8'h08 && req.sub == 16'h0 |=> rsp.w0 == 16'h0
		&& rsp.w1 == $past(req.data)) else $error("echo wrong");
	a_run_byte: assert property (
		hb && req.func == 8'h11 |=> rsp.run == (rsp.w1[0] ? 8'hff : 8'h00))
		else $error("run byte wrong");
	a_id_level: assert property (
		hb && req.func == 8'h2b && req.sub <= 16'h2 |=> !rsp.exc &&
		rsp.w0 == 16'h0001) else $error("identification wrong");
endmodule : mbd_slave_monitor
bind mbd_slave mbd_slave_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n),
	.clk_en(clk_en), .base_addr(base_addr), .cmd_busy(cmd_busy),
	.per_unit_address_mapping(per_unit_address_mapping), .req(req),
	.unit_wr(unit_wr), .radio_unit_identifier(radio_unit_identifier),
	.unit_data(unit_data), .bus_ev(bus_ev), .rsp(rsp),
	.listen_only(listen_only));
`default_nettype wire

// ---- tb/mbd_host_model.sv ----
// Host master model issuing frames and sampling answers
`timescale 1ns/1ns
`default_nettype none
module mbd_host_model (
	// Clock
	input  wire logic              ref_clk,
	// Request and answer
	output var  mbd_pkg::mbd_req_t req,
	input  wire mbd_pkg::mbd_rsp_t rsp,
	// Frame seen on the network
	output logic                   bus_msg
);
	initial req = '0;
	assign bus_msg = req.valid;
	task automatic send(input logic [7:0] a, f, input logic [15:0] s, d,
		input int n, output logic got);
		@(posedge ref_clk) #1;
		req = {1'b1, a, f, s, d};
		repeat (n) @(posedge ref_clk);
		#1;
		got = rsp.valid;
		req.valid = 1'b0;
	endtask : send
endmodule : mbd_host_model
`default_nettype wire

// ---- tb/tb_mbd_slave.sv ----
// Self-checking bench for the diagnostic and status responder
`timescale 1ns/1ns
`default_nettype none
module tb_mbd_slave;
	logic ref_clk = 1'b0, rst_n = 1'b0, cmd_busy = 1'b0, unit_wr = 1'b0;
	logic per_unit_address_mapping = 1'b1, listen_only, host_msg, g;
	logic comm_err = 1'b0, overrun = 1'b0, nak = 1'b0, clk_en = 1'b1;
	logic [5:0]         radio_unit_identifier = 6'h0;
	mbd_pkg::mbd_unit_t udata = '0;
	mbd_pkg::mbd_req_t  req;
	mbd_pkg::mbd_rsp_t  rsp;
	logic [15:0]        e0, m0;
	logic [15:0]        bad [5] = '{16'h3, 16'h5, 16'h9, 16'h13, 16'hffff};
	int                 num_errors = 0, check_count = 0;
	always #50 ref_clk = ~ref_clk;
	mbd_host_model host (.ref_clk(ref_clk), .req(req), .rsp(rsp),
		.bus_msg(host_msg));
	mbd_slave DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.base_addr(8'h10), .cmd_busy(cmd_busy), .unit_wr(unit_wr),
		.per_unit_address_mapping(per_unit_address_mapping),
		.radio_unit_identifier(radio_unit_identifier), .unit_data(udata),
		.req(req), .bus_ev({host_msg, comm_err, overrun, nak}),
		.rsp(rsp), .listen_only(listen_only));
	task automatic chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rq(input logic [7:0] a, f, input logic [15:0] s, d,
		input logic ans);
		logic got;
		host.send(a, f, s, d, 1, got);
		chk({31'h0, got}, {31'h0, ans});
		if (ans) begin
			chk({24'h0, rsp.func}, {24'h0, f});
		end
	endtask : rq
	task automatic ckw(input logic [15:0] w0, w1);
		chk({rsp.w0, rsp.w1}, {w0, w1});
	endtask : ckw
	task automatic ckx(input logic [7:0] c);
		chk({23'h0, rsp.exc, rsp.code}, {24'h1, c});
	endtask : ckx
	task automatic wu(input logic [5:0] id, input logic [4:0] k,
		input logic [8:0] c);
		@(posedge ref_clk) #1;
		unit_wr = 1'b1;
		radio_unit_identifier = id;
		udata = {k, c};
		@(posedge ref_clk) #1;
		unit_wr = 1'b0;
	endtask : wu
	task automatic ev(input logic [2:0] v);
		@(posedge ref_clk) #1;
		{comm_err, overrun, nak} = v;
		@(posedge ref_clk) #1;
		{comm_err, overrun, nak} = 3'h0;
	endtask : ev
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		#8000000;
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		wu(6'h03, 5'h0c, 9'h105);
		wu(6'h04, 5'h06, 9'h001);
		wu(6'h05, 5'h02, 9'h1c1);
		rq(8'h13, 8'h03, 16'h0, 16'h0, 1'b1);
		chk(rsp.w2, 32'h41400000);
		rq(8'h13, 8'h03, 16'h2, 16'h0, 1'b1);
		chk(rsp.w2, 32'h43828000);
		rq(8'h15, 8'h03, 16'h0, 16'h0, 1'b1);
		chk(rsp.w2, 32'h40000000);
		rq(8'h15, 8'h03, 16'h2, 16'h0, 1'b1);
		chk(rsp.w2, 32'h43410000);
		rq(8'h14, 8'h11, 16'h0, 16'h0, 1'b1);
		ckw(16'h0000, 16'h0000);
		chk({24'h0, rsp.run}, 32'h0);
		rq(8'h13, 8'h11, 16'h0, 16'h0, 1'b1);
		ckw(16'h000c, 16'h0105);
		chk({24'h0, rsp.run}, 32'hff);
		rq(8'h10, 8'h11, 16'h0, 16'h0, 1'b1);
		ckw(16'h00ff, 16'h0001);
		per_unit_address_mapping = 1'b0;
		rq(8'h10, 8'h03, 16'h1e, 16'h0, 1'b1);
		chk(rsp.w2, 32'h41400000);
		rq(8'h13, 8'h03, 16'h0, 16'h0, 1'b0);
		per_unit_address_mapping = 1'b1;
		rq(8'h10, 8'h08, 16'h000a, 16'h1234, 1'b1);
		ckw(16'h000a, 16'h1234);
		rq(8'h10, 8'h08, 16'h000b, 16'h0, 1'b1);
		ckw(16'h000b, 16'h0001);
		ev(3'h4);
		ev(3'h4);
		ev(3'h2);
		repeat (3) ev(3'h1);
		for (int i = 0; i < 2; i++) begin
			rq(8'h10 + 8'(3 * i), 8'h08, 16'h000c, 16'h0, 1'b1);
			ckw(16'h000c, 16'h0002);
			rq(8'h10 + 8'(3 * i), 8'h08, 16'h0010, 16'h0, 1'b1);
			ckw(16'h0010, 16'h0003);
			rq(8'h10 + 8'(3 * i), 8'h08, 16'h0012, 16'h0, 1'b1);
			ckw(16'h0012, 16'h0001);
		end
		rq(8'h10, 8'h08, 16'h000a, 16'h0, 1'b1);
		rq(8'h10, 8'h08, 16'h000c, 16'h0, 1'b1);
		ckw(16'h000c, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			rq(8'h10, 8'h08, bad[i], 16'h0, 1'b1);
			ckx(8'h03);
		end
		rq(8'h10, 8'h08, 16'h0001, 16'habcd, 1'b1);
		ckw(16'h0001, 16'habcd);
		rq(8'h10, 8'h0b, 16'h0, 16'h0, 1'b1);
		ckw(16'h0000, 16'h0001);
		rq(8'h10, 8'h08, 16'h000e, 16'h0, 1'b1);
		ckw(16'h000e, 16'h0002);
		rq(8'h13, 8'h08, 16'h0, 16'hbeef, 1'b1);
		ckw(16'h0000, 16'hbeef);
		rq(8'h10, 8'h08, 16'h0004, 16'h0, 1'b0);
		chk({31'h0, listen_only}, 32'h1);
		rq(8'h13, 8'h0b, 16'h0, 16'h0, 1'b0);
		rq(8'h10, 8'h08, 16'h0001, 16'h0, 1'b0);
		chk({31'h0, listen_only}, 32'h0);
		rq(8'h10, 8'h08, 16'h0002, 16'h0, 1'b1);
		ckw(16'h0002, 16'h0000);
		rq(8'h10, 8'h0b, 16'h0, 16'h0, 1'b1);
		e0 = rsp.w1;
		rq(8'h10, 8'h08, 16'h0, 16'h0, 1'b1);
		rq(8'h13, 8'h08, 16'h0, 16'h0, 1'b1);
		rq(8'h10, 8'h55, 16'h0, 16'h0, 1'b1);
		ckx(8'h01);
		rq(8'h10, 8'h0c, 16'h0, 16'h0, 1'b1);
		m0 = rsp.w2[15:0];
		ckw(16'h0000, e0 + 16'h2);
		rq(8'h50, 8'h03, 16'h0, 16'h0, 1'b0);
		rq(8'h13, 8'h0c, 16'h0, 16'h0, 1'b1);
		chk({16'h0, rsp.w2[15:0]}, {16'h0, m0 + 16'h2});
		host.send(8'h10, 8'h08, 16'h0, 16'h0, 65536, g);
		chk({31'h0, g}, 32'h1);
		rq(8'h10, 8'h0b, 16'h0, 16'h0, 1'b1);
		ckw(16'h0000, e0 + 16'h2);
		chk(rsp.log[55:24], 32'h80808080);
		cmd_busy = 1'b1;
		rq(8'h13, 8'h0b, 16'h0, 16'h0, 1'b1);
		ckw(16'hffff, e0 + 16'h2);
		rq(8'h10, 8'h03, 16'h0, 16'h0, 1'b1);
		ckx(8'h06);
		cmd_busy = 1'b0;
		rq(8'h13, 8'h2b, 16'h0, 16'h0, 1'b1);
		ckw(16'h0001, 16'h0000);
		rq(8'h13, 8'h2b, 16'h3, 16'h0, 1'b1);
		ckx(8'h02);
		@(posedge ref_clk) #1 clk_en = 1'b0;
		rq(8'h10, 8'h08, 16'h0, 16'h0, 1'b0);
		clk_en = 1'b1;
		rq(8'h13, 8'h0b, 16'h0, 16'h0, 1'b1);
		ckw(16'h0000, e0 + 16'h3);
		end_sim();
	end
endmodule : tb_mbd_slave
`default_nettype wire
